// >>> hw/adc_pipe_pkg.sv
// Shared constants and types for the two-step converter output pipeline.
`default_nettype none
package adc_pipe_pkg;
	localparam int STEP_W = 8;
	localparam int HALF_W = 4;
	localparam int COARSE_MSB = 7;
	localparam int COARSE_LSB = 4;
	localparam int FINE_MSB = 3;
	localparam int FINE_LSB = 0;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_CNT_W = 4;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_NS = 10;
	// Sampling edge to valid output, in half conversion clocks (2.5 clocks).
	localparam int LATENCY_HALF_CLOCKS = 5;
	localparam logic [STEP_W-1:0] RESULT_RST = 8'h00;
	localparam logic [HALF_W-1:0] HALF_RST = 4'h0;
	localparam logic [FIFO_CNT_W-1:0] INFLIGHT_MAX = 4'h3;

	typedef enum logic [2:0]
	{
		PH_SAMPLE = 3'b001,
		PH_HOLD = 3'b010,
		PH_COMPARE = 3'b100
	} comp_phase_t;
endpackage
`default_nettype wire

// >>> hw/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
module pin_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			meta_r <= RST_VAL;
			o_sync <= RST_VAL;
		end
		else
		begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> hw/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and an occupancy count.
`default_nettype none
module word_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int CNT_W = 4
)
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [CNT_W-1:0] o_count
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	logic do_push;
	logic do_pop;

	assign o_in_ready = (count_r != CNT_W'(DEPTH));
	assign o_out_valid = (count_r != '0);
	assign o_out_data = mem_r[rd_ptr_r];
	assign o_count = count_r;
	assign do_push = i_in_valid && o_in_ready;
	assign do_pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_ref_clk)
	begin
		if (do_push)
			mem_r[wr_ptr_r] <= i_in_data;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_r <= PTR_W'(wr_ptr_r + 1'b1);
			if (do_pop)
				rd_ptr_r <= PTR_W'(rd_ptr_r + 1'b1);
			if (do_push && !do_pop)
				count_r <= CNT_W'(count_r + 1'b1);
			else if (do_pop && !do_push)
				count_r <= CNT_W'(count_r - 1'b1);
		end
	end
endmodule
`default_nettype wire

// >>> hw/two_step_adc_output_pipeline.sv
// Clocked digital side of an 8-bit two-step converter: sampling, coarse/fine steps, output.
//
// What this block does
// R01: Drive result pins while output enable is low, release them while high.
// R02: Output enable defaults asserted through a pull-down when left open.
// R03: Result is the bitwise inverse of the step counted from the top.
// R04: Sample on the conversion clock falling edge, coarse and two fine stages.
// R05: Comparators step through sample/auto-zero, hold and compare phases.
// R06: Coarse result final at first rising edge; fine reference chosen from it.
// R07: Fine result final at the second rising edge after sampling.
// R08: Merged word presented at third rising edge, 2.5 clocks after sampling.
// R09: Coarse result in the upper nibble, fine result in the lower nibble.
// R10: The two fine stages alternate between successive samples.
// R11: Clamp enable high disables the clamp; it defaults high via pull-up.
// R12: With clamp enabled, clamp while clamp pulse is low; pulse defaults high.
// R13: Driving logic holds the conversion clock low when not clocking.
`default_nettype none
module two_step_adc_output_pipeline
	import adc_pipe_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_conv_clk,
	input wire logic [STEP_W-1:0] i_input_step,
	input wire logic i_output_enable_n,
	input wire logic i_clamp_enable_n,
	input wire logic i_clamp_pulse_n,
	input wire logic i_capture_ready,
	output logic [STEP_W-1:0] o_conversion_result,
	output logic [STEP_W-1:0] o_conversion_result_oe,
	output logic [HALF_W-1:0] o_coarse_result,
	output logic [HALF_W-1:0] o_fine_result,
	output logic [HALF_W-1:0] o_fine_reference_selection,
	output logic [2:0] o_comparator_phase,
	output logic o_clamp_active,
	output logic o_sample_dropped
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic conv_clk_s;
	logic oe_n_s;
	logic clamp_en_n_s;
	logic clamp_pulse_n_s;
	logic [STEP_W-1:0] step_s;

	// Idle conversion clock is low, so a reset value of zero sees no edge.
	pin_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_clk // R13
	(
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_async(i_conv_clk),
		.o_sync(conv_clk_s)
	);

	// Open enable pin is pulled low at the pad, so reset shows it asserted.
	pin_sync #(.WIDTH(3), .RST_VAL(3'b011)) u_sync_ctl // R02
	(
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_async({i_output_enable_n, i_clamp_enable_n, i_clamp_pulse_n}),
		.o_sync({oe_n_s, clamp_en_n_s, clamp_pulse_n_s})
	);

	pin_sync #(.WIDTH(STEP_W), .RST_VAL(RESULT_RST)) u_sync_step
	(
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_async(i_input_step),
		.o_sync(step_s)
	);

	// ----------------------------------------------------------------
	// Conversion clock edges
	// ----------------------------------------------------------------
	logic conv_prev_r;
	logic rise_evt;
	logic fall_evt;

	// Edges are found on the synchronised pin, two reference clocks after the pin moves.
	assign rise_evt = conv_clk_s && !conv_prev_r;
	assign fall_evt = !conv_clk_s && conv_prev_r;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			conv_prev_r <= 1'b0;
		else
			conv_prev_r <= conv_clk_s;
	end

	// ----------------------------------------------------------------
	// Comparator phase
	// ----------------------------------------------------------------
	comp_phase_t phase_r;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			phase_r <= PH_SAMPLE;
		else
		begin
			case (phase_r)
				PH_SAMPLE:
					if (fall_evt)
						phase_r <= PH_HOLD; // R05
				PH_HOLD:
					if (rise_evt)
						phase_r <= PH_COMPARE; // R05
				PH_COMPARE:
					phase_r <= PH_SAMPLE; // R05
				default:
					phase_r <= PH_SAMPLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sampling and space accounting
	// ----------------------------------------------------------------
	logic [STEP_W-1:0] held_r;
	logic held_v_r;
	logic fine_v_r;
	logic push_r;
	logic [STEP_W-1:0] push_word_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [STEP_W-1:0] fifo_out_data;
	logic [FIFO_CNT_W-1:0] fifo_count;
	logic [FIFO_CNT_W-1:0] inflight;
	logic accept;

	// A sample is taken only if every word in flight still has a FIFO slot.
	assign inflight = FIFO_CNT_W'(held_v_r) + FIFO_CNT_W'(fine_v_r) + FIFO_CNT_W'(push_r);
	assign accept = fall_evt && (FIFO_CNT_W'(fifo_count + inflight) < FIFO_CNT_W'(FIFO_DEPTH));

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			held_r <= RESULT_RST;
			held_v_r <= 1'b0;
			o_sample_dropped <= 1'b0;
		end
		else
		begin
			o_sample_dropped <= fall_evt && !accept;
			if (accept)
			begin
				held_r <= step_s; // R04
				held_v_r <= 1'b1; // R04
			end
			else if (rise_evt)
				held_v_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Coarse step and alternating fine stages
	// ----------------------------------------------------------------
	logic [HALF_W-1:0] stage_coarse_r [2];
	logic [HALF_W-1:0] stage_low_r [2];
	logic sel_r;
	logic fsel_r;
	logic [HALF_W-1:0] cur_low;

	// A new sample lands in the idle stage while the other one finishes its fine step.
	// The fine half is read from the stage that was filled one rising edge earlier.
	assign cur_low = stage_low_r[fsel_r];

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_coarse_result <= HALF_RST;
			o_fine_reference_selection <= HALF_RST;
			stage_coarse_r <= '{HALF_RST, HALF_RST};
			stage_low_r <= '{HALF_RST, HALF_RST};
			sel_r <= 1'b0;
			fsel_r <= 1'b0;
			fine_v_r <= 1'b0;
		end
		else if (rise_evt)
		begin
			fine_v_r <= held_v_r;
			if (held_v_r)
			begin
				o_coarse_result <= ~held_r[COARSE_MSB:COARSE_LSB]; // R06 R03
				o_fine_reference_selection <= ~held_r[COARSE_MSB:COARSE_LSB]; // R06
				stage_coarse_r[sel_r] <= ~held_r[COARSE_MSB:COARSE_LSB];
				stage_low_r[sel_r] <= held_r[FINE_MSB:FINE_LSB];
				fsel_r <= sel_r;
				sel_r <= !sel_r; // R10
			end
		end
	end

	// ----------------------------------------------------------------
	// Fine result and merge
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_fine_result <= HALF_RST;
			push_r <= 1'b0;
			push_word_r <= RESULT_RST;
		end
		else
		begin
			push_r <= rise_evt && fine_v_r;
			if (rise_evt && fine_v_r)
			begin
				o_fine_result <= ~cur_low; // R07 R03
				push_word_r <= {stage_coarse_r[fsel_r], ~cur_low}; // R09 R03
			end
		end
	end

	word_fifo #(.WIDTH(STEP_W), .DEPTH(FIFO_DEPTH), .CNT_W(FIFO_CNT_W)) u_fifo
	(
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_in_valid(push_r),
		.o_in_ready(fifo_in_ready),
		.i_in_data(push_word_r),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(rise_evt && i_capture_ready),
		.o_out_data(fifo_out_data),
		.o_count(fifo_count)
	);

	// ----------------------------------------------------------------
	// Output pins and clamp
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_conversion_result <= RESULT_RST;
			o_conversion_result_oe <= '1;
			o_clamp_active <= 1'b0;
			o_comparator_phase <= PH_SAMPLE;
		end
		else
		begin
			// A word leaves the buffer only on a rising edge while the host is ready.
			if (rise_evt && i_capture_ready && fifo_out_valid)
				o_conversion_result <= fifo_out_data; // R08
			o_conversion_result_oe <= {STEP_W{!oe_n_s}}; // R01
			o_clamp_active <= !clamp_en_n_s && !clamp_pulse_n_s; // R11 R12
			o_comparator_phase <= phase_r;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_OE_FOLLOWS_PIN: assert property ( // R01
		oe_n_s |=> (o_conversion_result_oe == '0))
		else $error("result pins driven while output enable is high");
	AST_OE_DRIVES: assert property ( // R01
		!oe_n_s |=> (o_conversion_result_oe == '1))
		else $error("result pins released while output enable is low");
	AST_SAMPLE_ON_FALL: assert property ( // R04
		$rose(held_v_r) |-> $past(fall_evt) && (held_r == $past(step_s)))
		else $error("sample captured away from a falling edge");
	AST_PHASE_HOLD: assert property ( // R05
		(phase_r == PH_HOLD) && rise_evt |=> (phase_r == PH_COMPARE) ##1 (phase_r == PH_SAMPLE))
		else $error("comparator phase sequence broken");
	AST_COARSE_INV: assert property ( // R06
		rise_evt && held_v_r |=> (o_coarse_result == ~$past(held_r[COARSE_MSB:COARSE_LSB]))
			&& (o_fine_reference_selection == o_coarse_result))
		else $error("coarse result or fine reference wrong");
	AST_FINE_INV: assert property ( // R07
		rise_evt && fine_v_r |=> (o_fine_result == ~$past(cur_low)) && push_r)
		else $error("fine result not final on second rising edge");
	AST_MERGE: assert property ( // R09
		push_r |-> (push_word_r[FINE_MSB:FINE_LSB] == o_fine_result) && fifo_in_ready)
		else $error("merged word wrong or FIFO overflow");
	AST_OUT_ON_RISE: assert property ( // R08
		(o_conversion_result != $past(o_conversion_result)) |-> $past(rise_evt))
		else $error("result changed away from a rising edge");
	AST_ALTERNATE: assert property ( // R10
		rise_evt && held_v_r |=> (sel_r != $past(sel_r)) && (fsel_r == $past(sel_r)))
		else $error("fine stages did not alternate");
	AST_CLAMP: assert property ( // R11
		clamp_en_n_s |=> !o_clamp_active)
		else $error("clamp active while clamp is disabled");
	AST_CLAMP_PULSE: assert property ( // R12
		!clamp_en_n_s && !clamp_pulse_n_s |=> o_clamp_active)
		else $error("clamp not active during low clamp pulse");
	AST_INFLIGHT: assert property ( // R08
		(inflight <= INFLIGHT_MAX)
			&& ((int'(fifo_count) + int'(inflight)) <= FIFO_DEPTH))
		else $error("too many words in flight");
	AST_POP_WORD: assert property ( // R08
		rise_evt && i_capture_ready && fifo_out_valid |=> (o_conversion_result == $past(fifo_out_data)))
		else $error("popped word not presented on the result pins");
	AST_PHASE_SAMPLE: assert property ( // R05
		(phase_r == PH_SAMPLE) && fall_evt |=> (phase_r == PH_HOLD))
		else $error("falling edge did not move the comparators to hold");
	AST_CLAMP_RELEASE: assert property ( // R12
		!clamp_en_n_s && clamp_pulse_n_s |=> !o_clamp_active)
		else $error("clamp active while clamp pulse is high");
endmodule
`default_nettype wire

// >>> testbench/host_capture.sv
// Host capture model that latches the converter's result bus.
`default_nettype none
module host_capture
	import adc_pipe_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_conv_clk,
	input wire logic i_stall,
	input wire logic [STEP_W-1:0] i_bus,
	output logic o_capture_ready,
	output logic [STEP_W-1:0] o_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Stalling is only ever commanded by a scenario that wants the buffer to fill.
	assign o_capture_ready = !i_stall;
	// In pulses held high for five cycles the word settles two reference clocks before the falling edge, so it is latched there.
	always_ff @(negedge i_conv_clk)
	begin
		o_word <= i_bus;
	end
endmodule
`default_nettype wire

// >>> testbench/two_step_adc_output_pipeline_test.sv
// Self-checking testbench for the two-step converter output pipeline.
`default_nettype none
module two_step_adc_output_pipeline_test
	import adc_pipe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic conv_clk = 1'b0;
	logic [STEP_W-1:0] step = 8'h00;
	logic oe_n = 1'b0;
	logic clamp_en_n = 1'b1;
	logic clamp_pulse_n = 1'b1;
	logic stall = 1'b0;
	logic ready;
	logic [STEP_W-1:0] result, result_oe, captured;
	wire logic [STEP_W-1:0] bus;
	logic [HALF_W-1:0] coarse, fine, fine_ref;
	logic [2:0] phase;
	logic clamp_act, dropped;
	int fail_count = 0;
	int comparisons = 0;
	int drop_n = 0;
	logic [STEP_W-1:0] steps [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};

	always #5 i_ref_clk = ~i_ref_clk;

	for (genvar g = 0; g < STEP_W; g++)
	begin : g_pin
		assign bus[g] = result_oe[g] ? result[g] : 1'bz;
	end

	always @(posedge i_ref_clk)
	begin
		if (dropped === 1'b1)
			drop_n++;
	end

	two_step_adc_output_pipeline dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
		.i_conv_clk(conv_clk), .i_input_step(step), .i_output_enable_n(oe_n),
		.i_clamp_enable_n(clamp_en_n), .i_clamp_pulse_n(clamp_pulse_n),
		.i_capture_ready(ready), .o_conversion_result(result),
		.o_conversion_result_oe(result_oe), .o_coarse_result(coarse),
		.o_fine_result(fine), .o_fine_reference_selection(fine_ref),
		.o_comparator_phase(phase), .o_clamp_active(clamp_act), .o_sample_dropped(dropped));

	host_capture host (.i_ref_clk(i_ref_clk), .i_conv_clk(conv_clk), .i_stall(stall),
		.i_bus(bus), .o_capture_ready(ready), .o_word(captured));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [STEP_W-1:0] got, input logic [STEP_W-1:0] exp);
		comparisons++;
		if (got !== exp)
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			fail_count++;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	// One conversion clock pulse; the clock rests low between pulses.
	task automatic pulse(input logic [STEP_W-1:0] s, input int h);
		step <= s;
		cyc(1);
		conv_clk <= 1'b1;
		cyc(h);
		conv_clk <= 1'b0;
		cyc(h);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reset_values;
		check(result, RESULT_RST);
		check(result_oe, 8'hFF);
		check({5'h0, phase}, {5'h0, PH_SAMPLE});
	endtask

	// Coarse and fine halves of one sample are never shown together, so they are kept here.
	task automatic codes;
		logic [HALF_W-1:0] c_seen;
		logic [HALF_W-1:0] f_seen;
		foreach (steps[i])
		begin
			pulse(steps[i], 5);
			check({5'h0, phase}, {5'h0, PH_HOLD});
			pulse(8'hA5, 5);
			check({4'h0, coarse}, {4'h0, ~steps[i][7:4]});
			check({4'h0, fine_ref}, {4'h0, ~steps[i][7:4]});
			c_seen = coarse;
			pulse(8'hA5, 5);
			check({4'h0, fine}, {4'h0, ~steps[i][3:0]});
			f_seen = fine;
			check({7'h0, result === ~steps[i]}, 8'h00);
			pulse(8'hA5, 5);
			check(result, ~steps[i]);
			check(result, {c_seen, f_seen});
			check(captured, ~steps[i]);
		end
	endtask

	task automatic back_to_back;
		for (int i = 0; i < 6; i++)
		begin
			pulse(STEP_W'(8'h11 * (i + 1)), 2);
			if (i >= 3)
				check(result, ~STEP_W'(8'h11 * (i - 2)));
		end
		check(STEP_W'(drop_n), 8'h00);
	endtask

	task automatic output_enable;
		oe_n <= 1'b1;
		cyc(5);
		check(bus, 8'hZZ);
		check(result_oe, 8'h00);
		oe_n <= 1'b0;
		cyc(5);
		// The last word out of the back-to-back run was step 8'h33.
		check(bus, 8'hCC);
	endtask

	task automatic clamp;
		clamp_en_n <= 1'b0;
		clamp_pulse_n <= 1'b0;
		cyc(5);
		check({7'h0, clamp_act}, 8'h01);
		clamp_pulse_n <= 1'b1;
		cyc(5);
		check({7'h0, clamp_act}, 8'h00);
		clamp_pulse_n <= 1'b0;
		clamp_en_n <= 1'b1;
		cyc(5);
		check({7'h0, clamp_act}, 8'h00);
		clamp_pulse_n <= 1'b1;
	endtask

	// The host stalls until samples are lost, then drains the buffer.
	task automatic fill_and_drain;
		drop_n = 0;
		stall <= 1'b1;
		for (int i = 0; i < 12; i++)
			pulse(STEP_W'(8'h30 + i), 5);
		check({7'h0, drop_n == 0}, 8'h00);
		stall <= 1'b0;
		for (int i = 0; i < 14; i++)
			pulse(8'h77, 5);
		check(result, 8'h88);
		check(captured, 8'h88);
	endtask

	initial
	begin
		cyc(2);
		reset_values();
		i_srst <= 1'b0;
		cyc(4);
		codes();
		back_to_back();
		output_enable();
		clamp();
		fill_and_drain();
		print_verdict();
	end
endmodule
`default_nettype wire
